/* design/adcd_core.sv */
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
// Contract
// [R1] Aux conversion also converts the second reference through converter one into group B.
// [R2] Host treats a reference reading outside 2.990V..3.014V as out of tolerance.
// [R3] Host compares overlap pairs to verify converter two and converter three.
// [R4] Overlap measurement takes 384us fastest up to 67119us slowest, per mode table.
// [R5] Overlap stores converter one cell 7 in slot 8, converter two cell 13 in 14.
// [R6] Mux test steps all channels; flag 1 on any failure, 0 if all pass.
// [R7] Mux failure flag is 1 after power-on reset and after status clear.
// [R8] Mux test lasts about 400us from reference-powered state, 4.5ms from standby.
// [R9] Host may poll for completion of the mux test instead of waiting.
// [R10] Self test feeds the filter a 1-bit test stream instead of the modulator.
// [R11] Self test conversion time equals the matching regular conversion in every mode.
// [R12] Self test writes 16-bit words into the regular command's result groups.
// [R13] Option 01 yields 0x9565, 0x9553, else 0x9555 by mode.
// [R14] Option 10 yields 0x6A9A, 0x6AAC, else 0x6AAA by mode.
// [R15] Separate self tests exist for cell, auxiliary and status results.
// [R16] Cell clear sets every byte of the six cell groups to 0xFF.
// [R17] Aux clear sets aux groups to 0xFF except last four registers of group D.
// [R18] Status clear keeps revision field and reserved bits reading zero.
// [R19] Status clear sets all over/undervoltage, mux failure and thermal flags to 1.
// [R20] Status clear presets sum, die temperature and supply results to 0xFF.
// [R21] Reading status group B clears the thermal shutdown flag afterwards.
// [R22] Busy is reported while a diagnostic or self test conversion runs.
module adcd_core import adcd_pkg::*; #(
    parameter int US_TICK_CYCLES = US_TICK_DEF,
    parameter logic [3:0] REV_CODE = 4'h3 // Arbitrary value
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_ref_powered,
    input wire logic i_thermal_event,
    input wire logic i_mux_decode_ok,
    input wire logic i_mod_bit,
    input wire logic [15:0] i_adc1_word,
    input wire logic [15:0] i_adc2_word,
    input wire logic [15:0] i_adc3_word,
    input wire logic [15:0] i_ref2_word,
    output logic o_busy,
    output logic [3:0] o_mux_chan,
    output logic o_filter_bit,
    output logic o_selftest_active
);
    adcd_state_type state_reg;
    adcd_op_type op_reg;
    logic [2:0] mode_reg;
    logic [1:0] opt_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [17:0] us_reg;
    logic [31:0] tick_reg;
    logic fail_reg;
    logic mux_flag_reg;
    logic thermal_shutdown_flag_reg;
    logic [FLAGS_W-1:0] ovuv_reg;
    logic [15:0] res_mem [NUM_WORDS];
    logic [15:0] pattern;
    logic [31:0] rdata;

    function automatic logic in_range(input int idx, input int lo, input int hi);
        return (idx >= lo) && (idx <= hi);
    endfunction

    function automatic logic is_selftest(input adcd_op_type op);
        return (op == CMD_CELL_SELFTEST) || (op == CMD_AUX_SELFTEST) ||
            (op == CMD_STATUS_SELFTEST);
    endfunction

    // Length of a timed command in microseconds
    function automatic logic [17:0] dur_us(input adcd_op_type op, input logic [2:0] m,
        input logic reference_powered_state);
        case (op)
            CMD_OVERLAP_MEASURE: dur_us = OL_US[m];
            CMD_MUX_TEST: dur_us = reference_powered_state ? 18'(DIAG_REFERENCE_POWERED_STATE_US) : 18'(DIAG_STBY_US);
            CMD_CELL_SELFTEST: dur_us = CELL_US[m];
            CMD_AUX_CONVERT, CMD_AUX_SELFTEST: dur_us = AUX_US[m];
            CMD_STATUS_SELFTEST: dur_us = STAT_US[m];
            default: dur_us = 18'h00001;
        endcase
    endfunction

    // Bus decode; a bus access completes at the edge where ack is high
    wire req = i_wb_cyc & i_wb_stb;
    wire acc = req & ack_reg;
    wire sel_cmd = (i_wb_adr == ADDR_CMD);
    wire sel_status = (i_wb_adr == ADDR_STATUS);
    wire sel_res = i_wb_adr[ADDR_RES_BIT];
    wire [4:0] res_idx = i_wb_adr[6:2];
    wire idle = (state_reg == ST_IDLE);
    wire cmd_wr = acc & i_wb_we & sel_cmd & i_wb_sel[0] & i_wb_sel[1] & idle;
    wire status_rd = acc & ~i_wb_we & sel_status;

    // Command field decode
    wire [3:0] op_field = i_wb_dat[CMD_OP_LSB +: 4];
    wire [2:0] mode_field = i_wb_dat[CMD_MODE_LSB +: 3];
    wire [1:0] opt_field = i_wb_dat[CMD_OPT_LSB +: 2];
    wire adcd_op_type new_op = adcd_op_type'(op_field);
    wire clr_cell = cmd_wr & (new_op == CMD_CELL_CLEAR);
    wire clr_aux = cmd_wr & (new_op == CMD_AUX_CLEAR);
    wire clr_stat = cmd_wr & (new_op == CMD_STATUS_CLEAR);
    wire timed_op = (new_op == CMD_AUX_CONVERT) || (new_op == CMD_OVERLAP_MEASURE) ||
        (new_op == CMD_MUX_TEST) || is_selftest(new_op); // [R15]
    wire start = cmd_wr & timed_op;

    // Timer: one microsecond per tick window
    wire tick_end = (tick_reg == 32'(US_TICK_CYCLES - 1));
    wire run_done = (state_reg == ST_RUN) & tick_end & (us_reg == 18'h00000);
    wire storing = (state_reg == ST_STORE);
    wire diag_run = (state_reg == ST_RUN) & (op_reg == CMD_MUX_TEST);
    wire st_run = (state_reg == ST_RUN) & is_selftest(op_reg);

    // Busy commands are acked, then dropped
    // Engine state; busy covers run and store so polling sees it unfinished
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: state_reg <= start ? ST_RUN : ST_IDLE;
                ST_RUN: state_reg <= run_done ? ST_STORE : ST_RUN;
                ST_STORE: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    assign o_busy = ~idle; // [R22]

    // Latched command fields, readable back
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            op_reg <= CMD_NONE;
            mode_reg <= 3'h0;
            opt_reg <= 2'h0;
        end else if (cmd_wr) begin
            op_reg <= new_op;
            mode_reg <= mode_field;
            opt_reg <= opt_field;
        end
    end

    // Loads duration minus one so the run ends at zero
    // Microsecond timer; self tests share the regular tables
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            us_reg <= 18'h00000;
            tick_reg <= 32'h00000000;
        end else if (start) begin
            us_reg <= dur_us(new_op, mode_field, i_ref_powered) - 18'h00001; // [R4] [R8] [R11]
            tick_reg <= 32'h00000000;
        end else if (state_reg == ST_RUN) begin
            tick_reg <= tick_end ? 32'h00000000 : tick_reg + 32'h00000001;
            if (tick_end && us_reg != 18'h00000) begin
                us_reg <= us_reg - 18'h00001;
            end
        end
    end

    // Any low sample fails the walk
    // Decoder test walks every channel and accumulates failures
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_mux_chan <= 4'h0;
            fail_reg <= 1'b0;
        end else if (start) begin
            o_mux_chan <= 4'h0;
            fail_reg <= 1'b0;
        end else if (diag_run) begin
            fail_reg <= fail_reg | ~i_mux_decode_ok; // [R6]
            if (tick_end && o_mux_chan != MUX_LAST) begin
                o_mux_chan <= o_mux_chan + 4'h1;
            end
        end
    end

    // Clears only start while idle, so no store clash
    // Flags; a thermal event wins over the read clear
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mux_flag_reg <= 1'b1; // [R7]
            thermal_shutdown_flag_reg <= 1'b0;
            ovuv_reg <= '0;
        end else begin
            if (clr_stat) begin
                mux_flag_reg <= 1'b1; // [R7] [R19]
                ovuv_reg <= '1; // [R19]
            end else if (storing && op_reg == CMD_MUX_TEST) begin
                mux_flag_reg <= fail_reg; // [R6]
            end
            if (i_thermal_event || clr_stat) begin
                thermal_shutdown_flag_reg <= 1'b1; // [R19]
            end else if (status_rd) begin
                thermal_shutdown_flag_reg <= 1'b0; // [R21]
            end
        end
    end

    // Filter sees the test stream only while a self test runs
    // Self test stream and expected word
    adcd_selftest u_selftest (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_active(st_run),
        .i_option(opt_reg),
        .i_mode(mode_reg),
        .i_mod_bit(i_mod_bit),
        .o_filter_bit(o_filter_bit), // [R10]
        .o_pattern(pattern)
    );
    assign o_selftest_active = st_run;

    // Each word has its own write port
    // Result words: clears and end-of-conversion stores
    for (genvar gi = 0; gi < NUM_WORDS; gi++) begin : g_word
        wire in_cell = in_range(gi, CELL_FIRST, CELL_LAST);
        wire in_aux = in_range(gi, AUX_FIRST, AUX_LAST);
        wire in_stat = in_range(gi, STAT_FIRST, STAT_LAST);
        wire ol_slot = (gi == SLOT_C7) || (gi == SLOT_C8) || (gi == SLOT_C13) ||
            (gi == SLOT_C14);
        wire st_hit = (op_reg == CMD_CELL_SELFTEST && in_cell) ||
            (op_reg == CMD_AUX_SELFTEST && in_aux) ||
            (op_reg == CMD_STATUS_SELFTEST && in_stat); // [R12]
        wire conv_hit = (op_reg == CMD_AUX_CONVERT && in_aux) ||
            (op_reg == CMD_OVERLAP_MEASURE && ol_slot);
        wire clr_hit = (clr_cell & in_cell) | (clr_aux & in_aux) | (clr_stat & in_stat);
        wire w_en = clr_hit | (storing & (st_hit | conv_hit));
        logic [15:0] w_dat;
        always_comb begin
            w_dat = RES_CLEAR; // [R16] [R17] [R20]
            if (storing && st_hit) begin
                w_dat = pattern; // [R13] [R14]
            end else if (storing && op_reg == CMD_AUX_CONVERT) begin
                w_dat = (gi == SLOT_REF) ? i_ref2_word : i_adc1_word; // [R1]
            end else if (storing && op_reg == CMD_OVERLAP_MEASURE) begin
                w_dat = (gi == SLOT_C8) ? i_adc1_word :
                    (gi == SLOT_C13) ? i_adc3_word : i_adc2_word; // [R5]
            end
        end
        always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
                res_mem[gi] <= RES_CLEAR;
            end else if (w_en) begin
                res_mem[gi] <= w_dat;
            end
        end
    end

    // Low address bits ignored for results
    // Read data; reserved bits read zero, revision is constant
    assign rdata = sel_res ? {16'h0000, res_mem[res_idx]} :
        sel_cmd ? {22'h000000, opt_reg, 1'b0, mode_reg, op_reg} :
        sel_status ? {24'h000000, REV_CODE, i_ref_powered, thermal_shutdown_flag_reg, mux_flag_reg, o_busy} :
        (i_wb_adr == ADDR_FLAGS_LO) ? ovuv_reg[31:0] :
        (i_wb_adr == ADDR_FLAGS_HI) ? {28'h0000000, ovuv_reg[FLAGS_W-1:32]} : 32'h00000000;

    // Data captured with ack, stable while it stands
    // One wait state; every address answers, unmapped reads give zero
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= req & ~ack_reg;
            if (req && !ack_reg) begin
                dat_reg <= rdata; // [R18]
            end
        end
    end
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = dat_reg;

    // Counts apart from the timer, so a timer slip shows
    // Helper: cycles spent in a timed command
    logic [31:0] el_cnt;
    logic [31:0] dur_cyc;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            el_cnt <= 32'h00000000;
            dur_cyc <= 32'h00000000;
        end else if (start) begin
            el_cnt <= 32'h00000000;
            dur_cyc <= 32'(dur_us(new_op, mode_field, i_ref_powered)) * 32'(US_TICK_CYCLES);
        end else if (state_reg == ST_RUN) begin
            el_cnt <= el_cnt + 32'h00000001;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // Checks
    a_conv_length: assert property (run_done |-> el_cnt + 32'h1 == dur_cyc) // [R4]
        else $error("timed command length wrong");
    a_ol_fast_time: assert property (start && new_op == CMD_OVERLAP_MEASURE && // [R4]
        mode_field == MODE_FAST |=> dur_cyc == 32'(OL_US[MODE_FAST]) * 32'(US_TICK_CYCLES))
        else $error("overlap fast time wrong");
    a_overlap_slots: assert property (storing && op_reg == CMD_OVERLAP_MEASURE |=> // [R5]
        res_mem[SLOT_C8] == $past(i_adc1_word) && res_mem[SLOT_C14] == $past(i_adc2_word))
        else $error("overlap slot placement wrong");
    a_ref_store: assert property (storing && op_reg == CMD_AUX_CONVERT |=> // [R1]
        res_mem[SLOT_REF] == $past(i_ref2_word))
        else $error("second reference not stored");
    a_mux_result: assert property (storing && op_reg == CMD_MUX_TEST |=> // [R6]
        mux_flag_reg == $past(fail_reg))
        else $error("mux flag not from test");
    a_stat_clear: assert property (clr_stat |=> mux_flag_reg && thermal_shutdown_flag_reg && &ovuv_reg && // [R19]
        res_mem[STAT_FIRST] == RES_CLEAR && res_mem[STAT_LAST] == RES_CLEAR)
        else $error("status clear incomplete");
    a_cell_clear: assert property (clr_cell |=> res_mem[CELL_FIRST] == RES_CLEAR && // [R16]
        res_mem[CELL_LAST] == RES_CLEAR && $stable(res_mem[AUX_FIRST]))
        else $error("cell clear wrong");
    a_aux_clear: assert property (clr_aux |=> res_mem[AUX_LAST] == RES_CLEAR && // [R17]
        $stable(ovuv_reg) && $stable(res_mem[CELL_FIRST]))
        else $error("aux clear wrong");
    a_thermal_shutdown_flag_read: assert property (status_rd && !i_thermal_event |=> !thermal_shutdown_flag_reg) // [R21]
        else $error("thermal flag not cleared by read");
    a_st_pattern: assert property (storing && op_reg == CMD_CELL_SELFTEST && // [R14]
        opt_reg == OPT_10 && mode_reg == MODE_FAST |=> res_mem[CELL_FIRST] == PAT10_FAST)
        else $error("self test pattern wrong");
    a_busy_hold: assert property (start |=> o_busy [*2]) // [R22]
        else $error("busy not shown after start");

    a_mux_walk: assert property (storing && op_reg == CMD_MUX_TEST |-> // [R6]
        o_mux_chan == MUX_LAST)
        else $error("mux channels not all stepped");
    a_filter_pass: assert property (!st_run |=> o_filter_bit == $past(i_mod_bit)) // [R10]
        else $error("filter input not modulator");

    // Main scenarios
    c_overlap_done: cover property (storing && op_reg == CMD_OVERLAP_MEASURE);
    c_mux_fail: cover property (storing && op_reg == CMD_MUX_TEST && fail_reg);
    c_selftest_done: cover property (storing && is_selftest(op_reg));
    c_thermal_shutdown_flag_cleared: cover property (status_rd && thermal_shutdown_flag_reg);
    c_clear_cmd: cover property (clr_cell || clr_aux || clr_stat);
endmodule

/* design/adcd_pkg.sv */
package adcd_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 50;
    localparam int US_NS = 1000;
    localparam int US_TICK_DEF = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIAG_REFERENCE_POWERED_STATE_US = 400;
    localparam int DIAG_STBY_US = 4500;
    typedef logic [17:0] adcd_us_type;
    // Conversion times per mode, index 0 is the fastest filter mode
    localparam adcd_us_type OL_US [8] = '{18'd384, 18'd442, 18'd791, 18'd1024,
        18'd1490, 18'd2420, 18'd4282, 18'd67119};
    // Regular conversion times shared by the self tests; plain defaults
    localparam adcd_us_type CELL_US [8] = '{18'd300, 18'd400, 18'd700, 18'd1000,
        18'd1500, 18'd2400, 18'd4300, 18'd67000};
    localparam adcd_us_type AUX_US [8] = '{18'd200, 18'd300, 18'd500, 18'd700,
        18'd1000, 18'd1700, 18'd3000, 18'd45000};
    localparam adcd_us_type STAT_US [8] = '{18'd150, 18'd200, 18'd350, 18'd500,
        18'd700, 18'd1200, 18'd2100, 18'd30000};
    // Multiplexer channels stepped by the decoder test
    localparam logic [3:0] MUX_LAST = 4'hf;
    // Command opcodes
    typedef enum logic [3:0] {
        CMD_NONE = 4'h0,
        CMD_AUX_CONVERT = 4'h1,
        CMD_OVERLAP_MEASURE = 4'h2,
        CMD_MUX_TEST = 4'h3,
        CMD_CELL_SELFTEST = 4'h4,
        CMD_AUX_SELFTEST = 4'h5,
        CMD_STATUS_SELFTEST = 4'h6,
        CMD_CELL_CLEAR = 4'h7,
        CMD_AUX_CLEAR = 4'h8,
        CMD_STATUS_CLEAR = 4'h9
    } adcd_op_type;
    // Engine states, Gray along idle-run-store
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_STORE = 2'b11
    } adcd_state_type;
    // Register offsets (byte addresses)
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FLAGS_LO = 8'h08;
    localparam logic [7:0] ADDR_FLAGS_HI = 8'h0c;
    localparam int ADDR_RES_BIT = 7;
    // Command register fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_MODE_LSB = 4;
    localparam int CMD_OPT_LSB = 8;
    // Status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_MUXF = 1;
    localparam int STAT_THERMAL_SHUTDOWN_FLAG = 2;
    localparam int STAT_REFERENCE_POWERED_STATE = 3;
    localparam int STAT_REV_LSB = 4;
    // Result slots: 18 cells, G1..G5 REF G6..G9, SC DIE_TEMPERATURE_RESULT VA VD
    localparam int NUM_WORDS = 32;
    localparam int CELL_FIRST = 0;
    localparam int CELL_LAST = 17;
    localparam int AUX_FIRST = 18;
    localparam int AUX_LAST = 27;
    localparam int STAT_FIRST = 28;
    localparam int STAT_LAST = 31;
    localparam int SLOT_C7 = 6;
    localparam int SLOT_C8 = 7;
    localparam int SLOT_C13 = 12;
    localparam int SLOT_C14 = 13;
    localparam int SLOT_REF = 23;
    localparam int FLAGS_W = 36;
    localparam logic [15:0] RES_CLEAR = 16'hffff;
    // Self test options and expected words
    localparam logic [1:0] OPT_10 = 2'b10;
    localparam logic [2:0] MODE_FAST = 3'h0;
    localparam logic [2:0] MODE_SECOND = 3'h1;
    localparam logic [15:0] PAT01_FAST = 16'h9565;
    localparam logic [15:0] PAT01_SECOND = 16'h9553;
    localparam logic [15:0] PAT01_SLOW = 16'h9555;
    localparam logic [15:0] PAT10_FAST = 16'h6a9a;
    localparam logic [15:0] PAT10_SECOND = 16'h6aac;
    localparam logic [15:0] PAT10_SLOW = 16'h6aaa;
endpackage

/* design/adcd_selftest.sv */
`timescale 1ns/1ns
// Test stream source in front of the decimation filter
module adcd_selftest import adcd_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_active,
    input wire logic [1:0] i_option,
    input wire logic [2:0] i_mode,
    input wire logic i_mod_bit,
    output logic o_filter_bit,
    output logic [15:0] o_pattern
);
    logic phase_reg;
    logic [15:0] pat_next;
    wire test_bit = phase_reg ^ (i_option == OPT_10);

    // Expected filter word for the active option and mode
    assign pat_next = (i_option == OPT_10) ?
        ((i_mode == MODE_FAST) ? PAT10_FAST : (i_mode == MODE_SECOND) ? PAT10_SECOND : PAT10_SLOW) :
        ((i_mode == MODE_FAST) ? PAT01_FAST : (i_mode == MODE_SECOND) ? PAT01_SECOND : PAT01_SLOW);

    // Stream replaces the modulator bit only while a self test runs
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            phase_reg <= 1'b0;
            o_filter_bit <= 1'b0;
            o_pattern <= 16'h0000;
        end else begin
            phase_reg <= i_active ? ~phase_reg : 1'b0;
            o_filter_bit <= i_active ? test_bit : i_mod_bit;
            o_pattern <= pat_next;
        end
    end
endmodule

/* verif/adcd_afe_model.sv */
`timescale 1ns/1ns
// Stand-in for the analog front end feeding the diagnostic logic
module adcd_afe_model (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_break_mux,
    input wire logic i_heat,
    output logic [15:0] o_adc1_word,
    output logic [15:0] o_adc2_word,
    output logic [15:0] o_adc3_word,
    output logic [15:0] o_ref2_word,
    output logic o_mux_ok,
    output logic o_mod_bit,
    output logic o_thermal_event
);
    // Converters differ by a few codes so swapped overlap slots show up
    assign o_adc1_word = 16'h7530;
    assign o_adc2_word = 16'h7532;
    assign o_adc3_word = 16'h7534;
    assign o_ref2_word = 16'h7546; // About 3.002 V at 100 uV a code
    assign o_mux_ok = !i_break_mux;
    assign o_thermal_event = i_heat;
    // Modulator stream flips every cycle, so a stuck filter input is visible
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_mod_bit <= 1'b0;
        end else begin
            o_mod_bit <= !o_mod_bit;
        end
    end
endmodule

/* verif/tb_adcd_core.sv */
`timescale 1ns/1ns
module tb_adcd_core;
    import adcd_pkg::*;
    localparam logic [3:0] REV = 4'h5; // Arbitrary value
    logic i_mclk = 1'b0, i_rst = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic [7:0] i_wb_adr = 8'h00;
    logic [3:0] i_wb_sel = 4'h0;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
    logic o_wb_ack, o_busy, o_filter_bit, o_selftest_active, mux_ok, mod_bit, therm;
    logic i_ref_powered = 1'b1, brk = 1'b0, heat = 1'b0;
    logic [3:0] o_mux_chan;
    logic [15:0] w1, w2, w3, wr2;
    int n_mismatch = 0, n_checks = 0;

    adcd_afe_model afe (.i_mclk(i_mclk), .i_rst(i_rst), .i_break_mux(brk), .i_heat(heat),
        .o_adc1_word(w1), .o_adc2_word(w2), .o_adc3_word(w3), .o_ref2_word(wr2),
        .o_mux_ok(mux_ok), .o_mod_bit(mod_bit), .o_thermal_event(therm));
    // One-cycle microsecond tick keeps the slow diagnostics short
    adcd_core #(.US_TICK_CYCLES(1), .REV_CODE(REV)) uut (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
        .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .i_ref_powered(i_ref_powered), .i_thermal_event(therm), .i_mux_decode_ok(mux_ok),
        .i_mod_bit(mod_bit), .i_adc1_word(w1), .i_adc2_word(w2), .i_adc3_word(w3),
        .i_ref2_word(wr2), .o_busy(o_busy), .o_mux_chan(o_mux_chan),
        .o_filter_bit(o_filter_bit), .o_selftest_active(o_selftest_active));

    initial begin
        forever #25 i_mclk = ~i_mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge i_mclk);
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_sel} <= {2'b11, we, 4'hf};
        i_wb_adr <= adr;
        i_wb_dat <= dat;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 50);
        rd = o_wb_dat;
        {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'b000;
        if (n >= 50) begin
            n_mismatch++;
            results();
        end
    endtask

    function automatic logic [7:0] slot(input int i);
        return 8'(8'h80 + 4 * i);
    endfunction

    // Starts a command and counts busy cycles by polling, bounded
    task automatic run(input logic [3:0] op, input logic [2:0] m, input logic [1:0] opt,
        output logic [31:0] cyc, output logic st);
        logic [31:0] d;
        wb(1'b1, ADDR_CMD, {22'h0, opt, 1'b0, m, op}, d);
        cyc = 0;
        #1;
        st = o_selftest_active;
        while (o_busy === 1'b1 && cyc < 80000) begin
            @(posedge i_mclk);
            #1;
            cyc++;
        end
        if (cyc >= 80000) begin
            n_mismatch++;
            results();
        end
    endtask

    function automatic logic [31:0] pat(input logic [1:0] opt, input logic [2:0] m);
        if (opt == OPT_10) begin
            return {16'h0, m == MODE_FAST ? PAT10_FAST : m == MODE_SECOND ? PAT10_SECOND
                : PAT10_SLOW};
        end
        return {16'h0, m == MODE_FAST ? PAT01_FAST : m == MODE_SECOND ? PAT01_SECOND
            : PAT01_SLOW};
    endfunction

    initial begin
        logic [31:0] d, c, ex;
        logic st;
        logic [3:0] op;
        logic [2:0] m;
        logic [1:0] opt;
        int f;
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        #1;
        check({31'h0, o_filter_bit}, {31'h0, !mod_bit});
        wb(1'b0, ADDR_STATUS, 0, d);
        check(d, {24'h0, REV, 4'b1010});
        wb(1'b0, 8'h40, 0, d);
        check(d, 32'h0);
        // Aux conversion also measures the second reference
        run(CMD_AUX_CONVERT, 3'h0, 2'b00, c, st);
        check(c, 32'(AUX_US[0]) + 1);
        wb(1'b0, slot(SLOT_REF), 0, d);
        check(d, {16'h0, wr2});
        check({31'h0, d >= 29900 && d <= 30140}, 32'h1);
        wb(1'b0, slot(AUX_FIRST), 0, d);
        check(d, {16'h0, w1});
        // Overlap timing in two modes and slot placement
        for (int k = 0; k < 3; k += 2) begin
            run(CMD_OVERLAP_MEASURE, 3'(k), 2'b00, c, st);
            check(c, 32'(OL_US[k]) + 1);
        end
        wb(1'b0, slot(SLOT_C7), 0, d);
        check(d, {16'h0, w2});
        wb(1'b0, slot(SLOT_C8), 0, ex);
        check(ex, {16'h0, w1});
        check({31'h0, d - ex <= 4}, 32'h1);
        wb(1'b0, slot(SLOT_C13), 0, d);
        check(d, {16'h0, w3});
        wb(1'b0, slot(SLOT_C14), 0, d);
        check(d, {16'h0, w2});
        // Decoder test: passing from powered state, failing from standby
        run(CMD_MUX_TEST, 3'h0, 2'b00, c, st);
        check(c, DIAG_REFERENCE_POWERED_STATE_US + 1);
        check({28'h0, o_mux_chan}, {28'h0, MUX_LAST});
        wb(1'b0, ADDR_STATUS, 0, d);
        check({31'h0, d[STAT_MUXF]}, 32'h0);
        @(posedge i_mclk);
        i_ref_powered <= 1'b0;
        brk <= 1'b1;
        run(CMD_MUX_TEST, 3'h0, 2'b00, c, st);
        @(posedge i_mclk);
        brk <= 1'b0;
        check(c, DIAG_STBY_US + 1);
        wb(1'b0, ADDR_STATUS, 0, d);
        check({31'h0, d[STAT_MUXF]}, 32'h1);
        // Every self test, both options, first three modes
        for (int k = 0; k < 18; k++) begin
            op = 4'(4 + k / 6);
            m = 3'(k % 3);
            opt = (k % 6 < 3) ? 2'b01 : OPT_10;
            f = op == 4 ? CELL_FIRST : op == 5 ? AUX_FIRST : STAT_FIRST;
            ex = op == 4 ? CELL_US[m] : op == 5 ? AUX_US[m] : STAT_US[m];
            run(op, m, opt, c, st);
            check(c, ex + 1);
            check({31'h0, st}, 32'h1);
            wb(1'b0, slot(f), 0, d);
            check(d, pat(opt, m));
            wb(1'b0, slot(op == 4 ? CELL_LAST : op == 5 ? AUX_LAST : STAT_LAST), 0, d);
            check(d, pat(opt, m));
        end
        // Clears; cell and aux clears checked against neighbours they must not touch
        run(CMD_CELL_CLEAR, 3'h0, 2'b00, c, st);
        for (int i = CELL_FIRST; i <= CELL_LAST; i++) begin
            wb(1'b0, slot(i), 0, d);
            check(d, {16'h0, RES_CLEAR});
        end
        wb(1'b0, slot(AUX_FIRST), 0, d);
        check(d, pat(OPT_10, 3'h2));
        run(CMD_AUX_CLEAR, 3'h0, 2'b00, c, st);
        for (int i = AUX_FIRST; i <= AUX_LAST; i++) begin
            wb(1'b0, slot(i), 0, d);
            check(d, {16'h0, RES_CLEAR});
        end
        wb(1'b0, ADDR_FLAGS_LO, 0, d);
        check(d, 32'h0);
        heat <= 1'b1;
        @(posedge i_mclk);
        heat <= 1'b0;
        wb(1'b0, ADDR_STATUS, 0, d);
        check({31'h0, d[STAT_THERMAL_SHUTDOWN_FLAG]}, 32'h1);
        wb(1'b0, ADDR_STATUS, 0, d);
        check({31'h0, d[STAT_THERMAL_SHUTDOWN_FLAG]}, 32'h0);
        run(CMD_STATUS_CLEAR, 3'h0, 2'b00, c, st);
        for (int i = STAT_FIRST; i <= STAT_LAST; i++) begin
            wb(1'b0, slot(i), 0, d);
            check(d, {16'h0, RES_CLEAR});
        end
        wb(1'b0, ADDR_FLAGS_LO, 0, d);
        check(d, 32'hffffffff);
        wb(1'b0, ADDR_FLAGS_HI, 0, d);
        check(d, 32'h0000000f);
        wb(1'b0, ADDR_STATUS, 0, d);
        check(d, {24'h0, REV, 4'b0110});
        wb(1'b0, ADDR_STATUS, 0, d);
        check(d, {24'h0, REV, 4'b0010});
        results();
    end
endmodule
